// *** hw/fbpem_pkg.sv ***
// Package: constants, types and decode functions of the flash block program/erase map
package fbpem_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_HZ         = 200_000_000;
  localparam int PROG_BYTE_US   = 80;
  localparam int PROG_UNIT_MS   = 10;
  localparam int ERASE_BLK_MS   = 100;
  localparam int PROG_BYTE_CYC  = PROG_BYTE_US * (CLK_HZ / 1_000_000);
  localparam int ERASE_BLK_CYC  = ERASE_BLK_MS * (CLK_HZ / 1_000);
  localparam logic [1:0] MODE_CAP_CYC = 2'h3;

  // ==========================================================================
  // Array map
  // ==========================================================================
  localparam int NUM_BLOCKS          = 8;
  localparam logic [6:0]  UNIT_OFS_ZERO = 7'h00;
  localparam logic [15:0] UNIT_OFS_MASK = 16'h007F;
  localparam logic [23:0] MODE2_TOP  = 24'h00_FFFF;
  localparam logic [15:0] MODE3_TOP  = 16'hDFFF;
  localparam logic [15:0] ARRAY_BASE = 16'h0000;
  localparam logic [15:0] ARRAY_TOP  = 16'hFFFF;
  localparam logic [15:0] BLK4_BASE  = 16'h1000;
  localparam logic [15:0] BLK5_BASE  = 16'h8000;
  localparam logic [15:0] BLK6_BASE  = 16'hC000;
  localparam logic [15:0] BLK7_BASE  = 16'hE000;
  localparam logic [15:0] SMALL_BLK  = 16'h0400;
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;

  // Mode pin codes on the three port pins
  localparam logic [2:0] PINS_BOOT = 3'h3;
  localparam logic [2:0] PINS_UPGM = 3'h5;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {FBPEM_USER, FBPEM_BOOT, FBPEM_UPGM, FBPEM_PROGRAMMER} fbpem_mode_t;

  typedef struct packed {
    logic       hi;
    logic       lo;
    logic [2:0] port;
  } fbpem_pins_t;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [7:0]  data;
  } fbpem_wr_t;

  // ==========================================================================
  // Functions
  // ==========================================================================
  function automatic fbpem_mode_t mode_of(input fbpem_pins_t p);
    if (!p.hi && !p.lo) begin
      return FBPEM_PROGRAMMER;
    end
    if (p.port == PINS_BOOT) begin
      return FBPEM_BOOT;
    end
    if (p.port == PINS_UPGM) begin
      return FBPEM_UPGM;
    end
    return FBPEM_USER;
  endfunction

  function automatic logic in_map(input logic [23:0] a, input logic mode3);
    if (mode3) begin
      return (a[23:16] == 8'h00) && (a[15:0] <= MODE3_TOP);
    end
    return a <= MODE2_TOP;
  endfunction

  function automatic logic [2:0] block_of(input logic [15:0] a);
    if (a < BLK4_BASE) begin
      return {1'b0, a[11:10]};
    end
    if (a < BLK5_BASE) begin
      return 3'h4;
    end
    if (a < BLK6_BASE) begin
      return 3'h5;
    end
    if (a < BLK7_BASE) begin
      return 3'h6;
    end
    return 3'h7;
  endfunction

  function automatic logic [15:0] block_base(input logic [2:0] b);
    case (b)
      3'h4:    return BLK4_BASE;
      3'h5:    return BLK5_BASE;
      3'h6:    return BLK6_BASE;
      3'h7:    return BLK7_BASE;
      default: return 16'(SMALL_BLK * b);
    endcase
  endfunction

  function automatic logic [15:0] block_last(input logic [2:0] b);
    if (b == 3'h7) begin
      return ARRAY_TOP;
    end
    return 16'(block_base(3'(b + 3'h1)) - 16'h0001);
  endfunction

endpackage

// *** hw/fbpem_array.sv ***
// Flash array storage: one write port, one registered read port
`timescale 1ns/1ps
`default_nettype none
module fbpem_array #(
  parameter int ADDR_W = 16
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire fbpem_pkg::fbpem_wr_t wr_in,
  input  wire logic [15:0]       rd_addr_in,
  output logic [7:0]             rd_data_out
);
  localparam int DEPTH = 1 << ADDR_W;

  // Storage comes out of reset erased, as shipped
  logic [7:0] mem_q [0:DEPTH-1];
  logic [7:0] rd_q;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= fbpem_pkg::ERASED_BYTE;
      end
      rd_q <= 8'h00;
    end else begin
      if (wr_in.en) begin
        mem_q[wr_in.addr[ADDR_W-1:0]] <= wr_in.data;
      end
      rd_q <= mem_q[rd_addr_in[ADDR_W-1:0]];
    end
  end

  assign rd_data_out = rd_q;
endmodule
`default_nettype wire

// *** hw/fbpem_baud.sv ***
// Boot link bit-rate measurement from the width of the first low bit
`timescale 1ns/1ps
`default_nettype none
module fbpem_baud #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             en_in,
  input  wire logic             rx_in,
  output logic [CNT_W-1:0]      bit_cycles_out,
  output logic                  locked_out
);
  typedef enum {WAIT_IDLE, WAIT_FALL, MEASURE, LOCKED} fbpem_baud_st_t;

  fbpem_baud_st_t   st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] bits_q, bits_d;

  // Host sends a pattern whose first low stretch is one bit long
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    bits_d = bits_q;
    unique case (st_q)
      WAIT_IDLE: if (en_in && rx_in) begin
        st_d = WAIT_FALL;
      end
      WAIT_FALL: if (!rx_in) begin
        st_d  = MEASURE;
        cnt_d = CNT_W'(1);
      end
      MEASURE: begin
        if (rx_in) begin
          st_d   = LOCKED;
          bits_d = cnt_q;
        end else if (cnt_q != '1) begin
          cnt_d = CNT_W'(cnt_q + 1'b1);
        end
      end
      LOCKED: ;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q   <= WAIT_IDLE;
      cnt_q  <= '0;
      bits_q <= '0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      bits_q <= bits_d;
    end
  end

  assign bit_cycles_out = bits_q;
  assign locked_out     = (st_q == LOCKED);

  rate_capture_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_q == MEASURE && rx_in) |=> (locked_out && bit_cycles_out == $past(cnt_q)))
    else $error("Measured bit time not captured");
endmodule
`default_nettype wire

// *** hw/fbpem_top.sv ***
// Flash program/erase sequencer with boot-time mode capture and block map
//
// Operation
// - A program writes one 128-byte unit starting at low byte 00 or 80
// - Outside boot mode, erase acts on one whole block; no partial or byte erase
// - Eight blocks: four 1K, 28K at 1000, 16K at 8000, 8K at C000, E000
// - Address mode 2 maps 000000-00FFFF; mode 3 maps only 0000-DFFF
// - User mode reads the array and refuses every program or erase
// - Mode comes from mode pins held in reset, effective three clock edges after reset ends
// - Boot mode erase clears the whole array; no per-block erase there
// - User program mode erases any single block and programs any region
// - Erased bytes read back as FF; array starts erased
// - Boot erase is refused until link check and erase routine copied to RAM
// - Boot mode measures host serial bit rate and reports it in clock cycles per bit
// - Typical times: 80 us per programmed byte, 100 ms per erase
// - Two mode pins and three port pins are sampled at reset
// - Control and block-select writes need the register access enable
// - With write enable low, block-select bits cannot be set
`timescale 1ns/1ps
`default_nettype none
module fbpem_top #(
  parameter int PROG_CYC  = fbpem_pkg::PROG_BYTE_CYC,
  parameter int ERASE_CYC = fbpem_pkg::ERASE_BLK_CYC
) (
  input  wire logic              SYS_CLK_IN,
  input  wire logic              RST_IN,
  input  wire logic              MODE_SELECT_HI_IN,
  input  wire logic              MODE_SELECT_LO_IN,
  input  wire logic              PORT_MODE_SEL_2_IN,
  input  wire logic              PORT_MODE_SEL_1_IN,
  input  wire logic              PORT_MODE_SEL_0_IN,
  input  wire logic              SERIAL_RX_IN,
  input  wire logic              FLASH_REG_ACCESS_EN_IN,
  input  wire logic              SOFTWARE_WRITE_EN_IN,
  input  wire logic              ERASE_SEL_WR_IN,
  input  wire logic [7:0]        ERASE_SEL_IN,
  input  wire logic              BOOT_ROUTINE_READY_IN,
  input  wire logic              RD_REQ_IN,
  input  wire logic [23:0]       RD_ADDR_IN,
  input  wire logic              PROG_START_IN,
  input  wire logic [23:0]       PROG_ADDR_IN,
  input  wire logic              PROG_BYTE_VALID_IN,
  input  wire logic [7:0]        PROG_BYTE_IN,
  input  wire logic              ERASE_START_IN,
  output logic [7:0]             RD_DATA_OUT,
  output logic                   RD_VALID_OUT,
  output logic                   RD_HIT_OUT,
  output logic                   PROG_BYTE_READY_OUT,
  output logic                   BUSY_OUT,
  output logic                   DONE_OUT,
  output logic                   REJECT_OUT,
  output var fbpem_pkg::fbpem_mode_t MODE_OUT,
  output logic                   ADDR_MODE3_OUT,
  output logic [7:0]             ERASE_SEL_OUT,
  output logic [15:0]            BIT_CYCLES_OUT,
  output logic                   LINK_LOCKED_OUT
);
  // ==========================================================================
  // Pin synchronisers and mode capture
  // ==========================================================================
  fbpem_pkg::fbpem_pins_t pins_s1_q, pins_s2_q;
  logic                   rx_s1_q, rx_s2_q;

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pins_s1_q <= '0;
      pins_s2_q <= '0;
      rx_s1_q   <= 1'b1;
      rx_s2_q   <= 1'b1;
    end else begin
      pins_s1_q <= {MODE_SELECT_HI_IN, MODE_SELECT_LO_IN,
                    PORT_MODE_SEL_2_IN, PORT_MODE_SEL_1_IN, PORT_MODE_SEL_0_IN};
      pins_s2_q <= pins_s1_q;
      rx_s1_q   <= SERIAL_RX_IN;
      rx_s2_q   <= rx_s1_q;
    end
  end

  logic [1:0]             cap_q, cap_d;
  fbpem_pkg::fbpem_mode_t mode_q, mode_d;
  logic                   mode3_q, mode3_d;

  // The pins are held through reset, so the value two edges after release
  // is still the reset-time strap
  always_comb begin
    cap_d   = cap_q;
    mode_d  = mode_q;
    mode3_d = mode3_q;
    if (cap_q != fbpem_pkg::MODE_CAP_CYC) begin
      cap_d = 2'(cap_q + 2'h1);
    end
    if (cap_q == 2'(fbpem_pkg::MODE_CAP_CYC - 2'h1)) begin
      mode_d  = fbpem_pkg::mode_of(pins_s2_q);
      mode3_d = pins_s2_q.lo;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cap_q   <= 2'h0;
      mode_q  <= fbpem_pkg::FBPEM_USER;
      mode3_q <= 1'b0;
    end else begin
      cap_q   <= cap_d;
      mode_q  <= mode_d;
      mode3_q <= mode3_d;
    end
  end

  // ==========================================================================
  // Boot link rate and erase block select
  // ==========================================================================
  logic link_locked;

  fbpem_baud #(
    .CNT_W(16)
  ) u_baud (
    .clk_in        (SYS_CLK_IN),
    .rst_in        (RST_IN),
    .en_in         (mode_q == fbpem_pkg::FBPEM_BOOT),
    .rx_in         (rx_s2_q),
    .bit_cycles_out(BIT_CYCLES_OUT),
    .locked_out    (link_locked)
  );

  logic [7:0] sel_q, sel_d;

  always_comb begin
    sel_d = sel_q;
    if (ERASE_SEL_WR_IN && FLASH_REG_ACCESS_EN_IN) begin
      sel_d = ERASE_SEL_IN;
    end
    if (!SOFTWARE_WRITE_EN_IN) begin
      sel_d = 8'h00;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sel_q <= 8'h00;
    end else begin
      sel_q <= sel_d;
    end
  end

  logic [2:0] sel_idx;

  always_comb begin
    sel_idx = 3'h0;
    for (int i = 0; i < fbpem_pkg::NUM_BLOCKS; i++) begin
      if (sel_q[i]) begin
        sel_idx = 3'(i);
      end
    end
  end

  // ==========================================================================
  // Program / erase sequencer
  // ==========================================================================
  typedef enum {ST_IDLE, ST_PROG_DATA, ST_PROG_WAIT, ST_ERASE_SWEEP, ST_ERASE_WAIT} fbpem_st_t;

  fbpem_st_t            st_q, st_d;
  logic [15:0]          cur_q, cur_d;
  logic [15:0]          last_q, last_d;
  logic [31:0]          cnt_q, cnt_d;
  logic                 done_q, done_d;
  logic                 rej_q, rej_d;
  fbpem_pkg::fbpem_wr_t wr;
  logic                 ctrl_ok, can_write, prog_ok, erase_ok, is_boot;

  always_comb begin
    is_boot   = (mode_q == fbpem_pkg::FBPEM_BOOT);
    ctrl_ok   = FLASH_REG_ACCESS_EN_IN && SOFTWARE_WRITE_EN_IN;
    can_write = (mode_q != fbpem_pkg::FBPEM_USER);
    prog_ok   = ctrl_ok && can_write && fbpem_pkg::in_map(PROG_ADDR_IN, mode3_q)
                && (PROG_ADDR_IN[6:0] == fbpem_pkg::UNIT_OFS_ZERO);
    if (is_boot) begin
      erase_ok = ctrl_ok && BOOT_ROUTINE_READY_IN && link_locked;
    end else begin
      erase_ok = ctrl_ok && can_write && $onehot(sel_q);
    end
  end

  always_comb begin
    st_d   = st_q;
    cur_d  = cur_q;
    last_d = last_q;
    cnt_d  = cnt_q;
    done_d = 1'b0;
    rej_d  = 1'b0;
    wr     = '0;
    unique case (st_q)
      ST_IDLE: begin
        if (PROG_START_IN) begin
          if (prog_ok) begin
            st_d   = ST_PROG_DATA;
            cur_d  = PROG_ADDR_IN[15:0];
            last_d = PROG_ADDR_IN[15:0] | fbpem_pkg::UNIT_OFS_MASK;
          end else begin
            rej_d = 1'b1;
          end
        end else if (ERASE_START_IN) begin
          if (erase_ok) begin
            st_d = ST_ERASE_SWEEP;
            if (is_boot) begin
              cur_d  = fbpem_pkg::ARRAY_BASE;
              last_d = fbpem_pkg::ARRAY_TOP;
            end else begin
              cur_d  = fbpem_pkg::block_base(sel_idx);
              last_d = fbpem_pkg::block_last(sel_idx);
            end
          end else begin
            rej_d = 1'b1;
          end
        end
      end
      ST_PROG_DATA: begin
        if (PROG_BYTE_VALID_IN) begin
          wr    = '{en: 1'b1, addr: cur_q, data: PROG_BYTE_IN};
          st_d  = ST_PROG_WAIT;
          cnt_d = 32'h0000_0000;
        end
      end
      ST_PROG_WAIT: begin
        cnt_d = 32'(cnt_q + 32'h0000_0001);
        if (cnt_q == 32'(PROG_CYC - 1)) begin
          if (cur_q == last_q) begin
            st_d   = ST_IDLE;
            done_d = 1'b1;
          end else begin
            st_d  = ST_PROG_DATA;
            cur_d = 16'(cur_q + 16'h0001);
          end
        end
      end
      ST_ERASE_SWEEP: begin
        wr = '{en: 1'b1, addr: cur_q, data: fbpem_pkg::ERASED_BYTE};
        if (cur_q == last_q) begin
          st_d  = ST_ERASE_WAIT;
          cnt_d = 32'h0000_0000;
        end else begin
          cur_d = 16'(cur_q + 16'h0001);
        end
      end
      ST_ERASE_WAIT: begin
        cnt_d = 32'(cnt_q + 32'h0000_0001);
        if (cnt_q == 32'(ERASE_CYC - 1)) begin
          st_d   = ST_IDLE;
          done_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_q   <= ST_IDLE;
      cur_q  <= 16'h0000;
      last_q <= 16'h0000;
      cnt_q  <= 32'h0000_0000;
      done_q <= 1'b0;
      rej_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      cur_q  <= cur_d;
      last_q <= last_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
      rej_q  <= rej_d;
    end
  end

  // ==========================================================================
  // Array and read path
  // ==========================================================================
  logic [7:0] arr_rd;
  logic       rd_valid_q, rd_valid_d;
  logic       rd_hit_q, rd_hit_d;

  fbpem_array #(
    .ADDR_W(16)
  ) u_array (
    .clk_in     (SYS_CLK_IN),
    .rst_in     (RST_IN),
    .wr_in      (wr),
    .rd_addr_in (RD_ADDR_IN[15:0]),
    .rd_data_out(arr_rd)
  );

  always_comb begin
    rd_valid_d = RD_REQ_IN;
    rd_hit_d   = RD_REQ_IN && fbpem_pkg::in_map(RD_ADDR_IN, mode3_q);
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rd_valid_q <= 1'b0;
      rd_hit_q   <= 1'b0;
    end else begin
      rd_valid_q <= rd_valid_d;
      rd_hit_q   <= rd_hit_d;
    end
  end

  assign RD_DATA_OUT         = rd_hit_q ? arr_rd : 8'h00;
  assign RD_VALID_OUT        = rd_valid_q;
  assign RD_HIT_OUT          = rd_hit_q;
  assign PROG_BYTE_READY_OUT = (st_q == ST_PROG_DATA);
  assign BUSY_OUT            = (st_q != ST_IDLE);
  assign DONE_OUT            = done_q;
  assign REJECT_OUT          = rej_q;
  assign MODE_OUT            = mode_q;
  assign ADDR_MODE3_OUT      = mode3_q;
  assign ERASE_SEL_OUT       = sel_q;
  assign LINK_LOCKED_OUT     = link_locked;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);

  sequence idle_prog_req;
    st_q == ST_IDLE && PROG_START_IN;
  endsequence

  sequence boot_erase_go;
    st_q == ST_IDLE && !PROG_START_IN && ERASE_START_IN && is_boot && erase_ok;
  endsequence

  misaligned_prog_a: assert property (idle_prog_req ##0 (PROG_ADDR_IN[6:0] != 7'h00)
    |=> REJECT_OUT && !BUSY_OUT && !wr.en)
    else $error("Misaligned program not refused");

  user_refuse_a: assert property ((st_q == ST_IDLE && mode_q == fbpem_pkg::FBPEM_USER
    && (PROG_START_IN || ERASE_START_IN)) |=> REJECT_OUT ##1 !BUSY_OUT)
    else $error("User mode allowed a write");

  sel_locked_a: assert property (!SOFTWARE_WRITE_EN_IN |=> ERASE_SEL_OUT == 8'h00)
    else $error("Block select set without write enable");

  sel_access_a: assert property ((ERASE_SEL_WR_IN && !FLASH_REG_ACCESS_EN_IN
    && SOFTWARE_WRITE_EN_IN) |=> ERASE_SEL_OUT == $past(sel_q))
    else $error("Block select written without access enable");

  erase_fill_a: assert property ((st_q == ST_ERASE_SWEEP) |-> wr.en && wr.data == 8'hFF)
    else $error("Erase wrote a non-erased value");

  block_bound_a: assert property ((st_q == ST_ERASE_SWEEP && !is_boot)
    |-> fbpem_pkg::block_of(wr.addr) == sel_idx)
    else $error("Erase left its block");

  boot_whole_a: assert property (boot_erase_go
    |=> st_q == ST_ERASE_SWEEP && cur_q == 16'h0000 && last_q == 16'hFFFF)
    else $error("Boot erase not whole array");

  unit_bound_a: assert property ((wr.en && st_q == ST_PROG_DATA)
    |-> wr.addr[15:7] == last_q[15:7] && last_q[6:0] == 7'h7F)
    else $error("Program left its unit");

  map3_read_a: assert property ((RD_REQ_IN && mode3_q && RD_ADDR_IN[15:0] > 16'hDFFF)
    |=> RD_VALID_OUT && !RD_HIT_OUT)
    else $error("Mode 3 read hit above map");

  byte_time_a: assert property ((st_q == ST_PROG_WAIT && st_d != ST_PROG_WAIT)
    |-> cnt_q == 32'(PROG_CYC - 1))
    else $error("Byte program time wrong");

  boot_gate_a: assert property ((is_boot && ERASE_START_IN && !PROG_START_IN && st_q == ST_IDLE
    && (!link_locked || !BOOT_ROUTINE_READY_IN)) |=> REJECT_OUT)
    else $error("Boot erase before link check");
endmodule
`default_nettype wire

// *** sim/fbpem_cpu.sv ***
// Model of the CPU code that streams one program unit into the sequencer
`timescale 1ns/1ps
`default_nettype none
module fbpem_cpu (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       run_in,
  input  wire logic       slow_in,
  input  wire logic       ready_in,
  input  wire logic [7:0] seed_in,
  output logic            valid_out,
  output logic [7:0]      data_out = 8'h5A,
  output logic [7:0]      sent_out
);
  // ==========================================================================
  // Byte feeder
  // ==========================================================================
  // Byte i of a run carries seed+i; a released data line toggles every cycle
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in || !run_in) begin
      valid_out <= 1'b0;
      sent_out  <= 8'h00;
      data_out  <= ~data_out;
    end else if (valid_out && ready_in) begin
      sent_out  <= sent_out + 8'h01;
      valid_out <= (sent_out != 8'h7F) && !slow_in;
      data_out  <= (sent_out == 8'h7F || slow_in) ? ~data_out : seed_in + sent_out + 8'h01;
    end else if (!valid_out && sent_out != 8'h80) begin
      valid_out <= 1'b1;
      data_out  <= seed_in + sent_out;
    end else begin
      data_out  <= valid_out ? data_out : ~data_out;
    end
  end
endmodule
`default_nettype wire

// *** sim/flash_block_program_erase_map_tb.sv ***
// Self-checking testbench of the flash program/erase sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_block_program_erase_map_tb;
  localparam int P = 4;
  localparam int E = 8;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hi = 1'b1, lo = 1'b0, rx = 1'b1, acc = 1'b1, software_write_en = 1'b1, swr = 1'b0;
  logic        brdy = 1'b0, rq = 1'b0, ps = 1'b0, es = 1'b0, run = 1'b0, slow = 1'b0;
  logic [2:0]  port = 3'h0;
  logic [7:0]  esel = 8'h00, seed = 8'h00;
  logic [23:0] ra = 24'h00_0000, pa = 24'h00_0000;
  logic [7:0]  rdd, selo, pd, sent;
  logic [15:0] bitc;
  logic        rdv, hit, prdy, busy, done, rej, m3, lock, pv;
  fbpem_pkg::fbpem_mode_t mode;
  int          bad_count = 0;
  int          cmp_count = 0;

  fbpem_top #(.PROG_CYC(P), .ERASE_CYC(E)) DUT (
    .SYS_CLK_IN(clk), .RST_IN(rst), .MODE_SELECT_HI_IN(hi), .MODE_SELECT_LO_IN(lo),
    .PORT_MODE_SEL_2_IN(port[2]), .PORT_MODE_SEL_1_IN(port[1]), .PORT_MODE_SEL_0_IN(port[0]),
    .SERIAL_RX_IN(rx), .FLASH_REG_ACCESS_EN_IN(acc), .SOFTWARE_WRITE_EN_IN(software_write_en),
    .ERASE_SEL_WR_IN(swr), .ERASE_SEL_IN(esel), .BOOT_ROUTINE_READY_IN(brdy),
    .RD_REQ_IN(rq), .RD_ADDR_IN(ra), .PROG_START_IN(ps), .PROG_ADDR_IN(pa),
    .PROG_BYTE_VALID_IN(pv), .PROG_BYTE_IN(pd), .ERASE_START_IN(es), .RD_DATA_OUT(rdd),
    .RD_VALID_OUT(rdv), .RD_HIT_OUT(hit), .PROG_BYTE_READY_OUT(prdy), .BUSY_OUT(busy),
    .DONE_OUT(done), .REJECT_OUT(rej), .MODE_OUT(mode), .ADDR_MODE3_OUT(m3),
    .ERASE_SEL_OUT(selo), .BIT_CYCLES_OUT(bitc), .LINK_LOCKED_OUT(lock));

  fbpem_cpu cpu (.clk_in(clk), .rst_in(rst), .run_in(run), .slow_in(slow), .ready_in(prdy),
    .seed_in(seed), .valid_out(pv), .data_out(pd), .sent_out(sent));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Mode pins stay put well past capture, which lands three edges after release
  task automatic start_dev(input logic h, input logic l, input logic [2:0] p);
    @(posedge clk);
    rst <= 1'b1;
    hi <= h;
    lo <= l;
    port <= p;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic rd(input logic [23:0] a, input logic h, input logic [7:0] d);
    @(posedge clk);
    rq <= 1'b1;
    ra <= a;
    @(posedge clk);
    rq <= 1'b0;
    #1;
    chk("rd_valid", 1'b1, rdv);
    chk("rd_hit", h, hit);
    chk("rd_data", d, rdd);
  endtask

  task automatic op(input logic p, input logic [23:0] a, input logic rj);
    @(posedge clk);
    ps <= p;
    es <= !p;
    pa <= a;
    @(posedge clk);
    ps <= 1'b0;
    es <= 1'b0;
    #1;
    chk("reject", rj, rej);
    chk("busy", !rj, busy);
  endtask

  task automatic wait_done(input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) break;
    end
    chk("done", 1'b1, done);
    chk("busy_at_done", 1'b0, busy);
  endtask

  task automatic sel_wr(input logic [7:0] v, input logic [7:0] exp);
    @(posedge clk);
    swr <= 1'b1;
    esel <= v;
    @(posedge clk);
    swr <= 1'b0;
    #1;
    chk("erase_sel", exp, selo);
  endtask

  // Programs one unit with seed s, then reads it back with both neighbours
  task automatic prog(input logic [23:0] a, input logic [7:0] s, input logic sl);
    @(posedge clk);
    seed <= s;
    slow <= sl;
    run <= 1'b1;
    op(1'b1, a, 1'b0);
    wait_done(128 * (P + 4));
    chk("bytes_taken", 8'h80, sent);
    @(posedge clk) run <= 1'b0;
    for (int i = 0; i < 128; i++) begin
      rd(a + 24'(i), 1'b1, s + 8'(i));
    end
    rd(a - 24'h1, 1'b1, 8'hFF);
    rd(a + 24'h80, 1'b1, 8'hFF);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_user();
    start_dev(1'b1, 1'b1, 3'h0);
    chk("mode", fbpem_pkg::FBPEM_USER, mode);
    chk("addr_mode3", 1'b1, m3);
    rd(24'h00_DFFF, 1'b1, 8'hFF);
    rd(24'h00_E000, 1'b0, 8'h00);
    op(1'b1, 24'h00_0000, 1'b1);
    sel_wr(8'h01, 8'h01);
    op(1'b0, 24'h00_0000, 1'b1);
    $display("test user done");
  endtask

  task automatic t_upgm();
    start_dev(1'b1, 1'b0, 3'h5);
    chk("mode", fbpem_pkg::FBPEM_UPGM, mode);
    rd(24'h00_FFFF, 1'b1, 8'hFF);
    rd(24'h01_0000, 1'b0, 8'h00);
    op(1'b1, 24'h00_BF40, 1'b1);
    rd(24'h00_BF40, 1'b1, 8'hFF);
    prog(24'h00_BF80, 8'h10, 1'b0);
    prog(24'h00_C080, 8'h40, 1'b1);
    @(posedge clk) acc <= 1'b0;
    sel_wr(8'h40, 8'h00);
    op(1'b0, 24'h00_0000, 1'b1);
    @(posedge clk) acc <= 1'b1;
    sel_wr(8'h40, 8'h40);
    @(posedge clk) software_write_en <= 1'b0;
    sel_wr(8'h40, 8'h00);
    @(posedge clk) software_write_en <= 1'b1;
    sel_wr(8'hC0, 8'hC0);
    op(1'b0, 24'h00_0000, 1'b1);
    sel_wr(8'h40, 8'h40);
    op(1'b0, 24'h00_0000, 1'b0);
    wait_done(8192 + E + 20);
    rd(24'h00_C000, 1'b1, 8'hFF);
    rd(24'h00_C0FF, 1'b1, 8'hFF);
    rd(24'h00_DFFF, 1'b1, 8'hFF);
    rd(24'h00_BFFF, 1'b1, 8'h8F);
    $display("test user program done");
  endtask

  task automatic t_boot();
    start_dev(1'b1, 1'b0, 3'h3);
    chk("mode", fbpem_pkg::FBPEM_BOOT, mode);
    prog(24'h00_E000, 8'h77, 1'b0);
    @(posedge clk) brdy <= 1'b1;
    op(1'b0, 24'h00_0000, 1'b1);
    @(posedge clk);
    rx <= 1'b0;
    repeat (20) @(posedge clk);
    rx <= 1'b1;
    repeat (8) @(posedge clk);
    chk("bit_cycles", 16'h0014, bitc);
    chk("locked", 1'b1, lock);
    @(posedge clk) brdy <= 1'b0;
    op(1'b0, 24'h00_0000, 1'b1);
    @(posedge clk) brdy <= 1'b1;
    op(1'b0, 24'h00_0000, 1'b0);
    wait_done(65536 + E + 20);
    rd(24'h00_E000, 1'b1, 8'hFF);
    rd(24'h00_E07F, 1'b1, 8'hFF);
    $display("test boot done");
  endtask

  // Last unit of block 0 must survive an erase of block 1
  task automatic t_pgmr();
    start_dev(1'b0, 1'b0, 3'h0);
    chk("mode", fbpem_pkg::FBPEM_PROGRAMMER, mode);
    chk("addr_mode3", 1'b0, m3);
    prog(24'h00_0380, 8'h20, 1'b0);
    sel_wr(8'h02, 8'h02);
    op(1'b0, 24'h00_0000, 1'b0);
    wait_done(1024 + E + 20);
    rd(24'h00_0380, 1'b1, 8'h20);
    rd(24'h00_03FF, 1'b1, 8'h9F);
    $display("test programmer done");
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    wrap_up();
  end

  initial begin
    t_user();
    t_upgm();
    t_pgmr();
    t_boot();
    wrap_up();
  end
endmodule
`default_nettype wire
